/* File: verilog/pin_pkg.sv */
// Constants, mode enums and clock output settings for the master port pin block.
// Assumes a single 250 MHz system clock and an active-low asynchronous reset pin.
// Function
// - Reset enters on fall, exits on rise
// - Reset restores every register to default
// - Clock output at 1x, 2x, 4x, 8x
// - Slave select low during each SPI transaction
// - Strap high samples select pin at release
// - Select pin high boots over SPI
// - Select pin low boots over I2C
// - I2C clock pins are open-collector outputs
// - Second port data pin is open-collector bidirectional
// - SPI mode drives shared serial clock pin
// - SPI mode drives master data output pin
// - Unused master pins act as GPIO
// - Strap high starts self boot, low none
// - SPI mode captures master data input pin
package pin_pkg;
  typedef enum logic [1:0] {
    MODE_GPIO,
    MODE_I2C,
    MODE_SPI
  } port_mode_e;

  typedef enum logic [1:0] {
    CLK_MULT_1X,
    CLK_MULT_2X,
    CLK_MULT_4X,
    CLK_MULT_8X
  } clk_mult_e;

  localparam int unsigned CLK_SYS_MHZ        = 250;
  localparam int unsigned PIN_COUNT          = 6;
  localparam int unsigned PIN_SLAVE_SELECT   = 0;
  localparam int unsigned PIN_DATA_OUT       = 1;
  localparam int unsigned PIN_SHARED_CLOCK   = 2;
  localparam int unsigned PIN_SHARED_DATA    = 3;
  localparam int unsigned PIN_SECOND_CLOCK   = 4;
  localparam int unsigned PIN_SECOND_DATA    = 5;
  localparam int unsigned CLK_BASE_HALF      = 16;
  localparam int unsigned CLK_COUNT_WIDTH    = 8;
  localparam logic [5:0]  GPIO_RESET_VALUE   = 6'h00;
endpackage : pin_pkg

/* File: verilog/clock_out_divider.sv */
// Clock output generator: toggles at a base rate times 1, 2, 4 or 8.
// Assumes the multiplier select is steady except at reconfiguration.
`timescale 1ns/1ns
module clock_out_divider #(
  parameter int unsigned BASE_HALF = pin_pkg::CLK_BASE_HALF
) (
  input  wire logic                            clk_sys_in,
  input  wire logic                            rst_n_in,
  input  wire pin_pkg::clk_mult_e              mult_sel_in,
  output logic                                 clock_out
);
  logic [pin_pkg::CLK_COUNT_WIDTH-1:0] count_reg;
  logic [pin_pkg::CLK_COUNT_WIDTH-1:0] count_next;
  logic [pin_pkg::CLK_COUNT_WIDTH-1:0] half_limit;
  logic                                wrap;
  logic                                clock_reg;

  // Half period shrinks by the selected power of two
  assign half_limit = pin_pkg::CLK_COUNT_WIDTH'((BASE_HALF >> mult_sel_in) - 1);
  assign wrap       = (count_reg >= half_limit);
  assign count_next = wrap ? '0 : count_reg + 1'b1;
  assign clock_out  = clock_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
      clock_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      if (wrap) begin
        clock_reg <= ~clock_reg;
      end
    end
  end
endmodule : clock_out_divider

/* File: verilog/master_port_pins_boot_strap.sv */
// Pin multiplexer for the two master control ports, boot strap and clock output.
// Assumes pin inputs are synchronous to clk_sys_in and the pad ring resolves enables.
`timescale 1ns/1ns
module master_port_pins_boot_strap #(
  parameter int unsigned BASE_HALF = pin_pkg::CLK_BASE_HALF
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      boot_strap_select_in,
  input  wire pin_pkg::port_mode_e       first_port_mode_in,
  input  wire logic                      second_i2c_enable_in,
  input  wire pin_pkg::clk_mult_e        clock_mult_sel_in,
  input  wire logic [5:0]                gpio_drive_in,
  input  wire logic [5:0]                gpio_dir_in,
  input  wire logic                      spi_xfer_active_in,
  input  wire logic                      spi_sclk_in,
  input  wire logic                      spi_mosi_in,
  input  wire logic                      i2c_scl_low_in,
  input  wire logic                      i2c_sda_low_in,
  input  wire logic                      i2c2_scl_low_in,
  input  wire logic                      i2c2_sda_low_in,
  input  wire logic [5:0]                pin_in,
  output logic      [5:0]                pin_out,
  output logic      [5:0]                pin_oe_out,
  output logic      [5:0]                gpio_value_out,
  output logic                           spi_miso_out,
  output logic                           i2c_sda_out,
  output logic                           i2c2_sda_out,
  output logic                           boot_start_out,
  output logic                           boot_use_spi_out,
  output logic                           boot_use_i2c_out,
  output logic                           master_clock_output
);
  typedef enum logic {
    BOOT_SAMPLE,
    BOOT_IDLE
  } boot_state_e;

  boot_state_e boot_state_reg;
  boot_state_e boot_state_next;
  logic        boot_start_reg;
  logic        boot_spi_reg;
  logic        boot_i2c_reg;
  logic [5:0]  gpio_value_reg;
  logic        miso_reg;
  logic        sda_reg;
  logic        sda2_reg;

  logic        first_is_spi;
  logic        first_is_i2c;
  logic [5:0]  func_owned;
  logic [5:0]  func_out;
  logic [5:0]  func_oe;
  logic        sample_now;
  logic        strap_spi;

  // Which pins the master functions take from the GPIO
  assign first_is_spi = (first_port_mode_in == pin_pkg::MODE_SPI);
  assign first_is_i2c = (first_port_mode_in == pin_pkg::MODE_I2C);
  assign func_owned[pin_pkg::PIN_SLAVE_SELECT] = first_is_spi;
  assign func_owned[pin_pkg::PIN_DATA_OUT]     = first_is_spi;
  assign func_owned[pin_pkg::PIN_SHARED_CLOCK] = first_is_spi | first_is_i2c;
  assign func_owned[pin_pkg::PIN_SHARED_DATA]  = first_is_spi | first_is_i2c;
  assign func_owned[pin_pkg::PIN_SECOND_CLOCK] = second_i2c_enable_in;
  assign func_owned[pin_pkg::PIN_SECOND_DATA]  = second_i2c_enable_in;

  // Slave select low for the whole transaction
  assign func_out[pin_pkg::PIN_SLAVE_SELECT] = ~spi_xfer_active_in;
  assign func_oe[pin_pkg::PIN_SLAVE_SELECT]  = 1'b1;
  assign func_out[pin_pkg::PIN_DATA_OUT]     = spi_mosi_in;
  assign func_oe[pin_pkg::PIN_DATA_OUT]      = 1'b1;

  // Shared clock: push-pull in SPI, open drain in I2C
  assign func_out[pin_pkg::PIN_SHARED_CLOCK] = first_is_spi & spi_sclk_in;
  assign func_oe[pin_pkg::PIN_SHARED_CLOCK]  = first_is_spi | i2c_scl_low_in;

  // Shared data: input in SPI, open drain in I2C
  assign func_out[pin_pkg::PIN_SHARED_DATA]  = 1'b0;
  assign func_oe[pin_pkg::PIN_SHARED_DATA]   = first_is_i2c & i2c_sda_low_in;

  // Second port is I2C only, both lines open drain
  assign func_out[pin_pkg::PIN_SECOND_CLOCK] = 1'b0;
  assign func_oe[pin_pkg::PIN_SECOND_CLOCK]  = i2c2_scl_low_in;
  assign func_out[pin_pkg::PIN_SECOND_DATA]  = 1'b0;
  assign func_oe[pin_pkg::PIN_SECOND_DATA]   = i2c2_sda_low_in;

  // One owner per pin: master function or GPIO
  genvar g;
  generate
    for (g = 0; g < pin_pkg::PIN_COUNT; g++) begin : g_pin
      assign pin_out[g]    = func_owned[g] ? func_out[g] : gpio_drive_in[g];
      assign pin_oe_out[g] = func_owned[g] ? func_oe[g] : gpio_dir_in[g];
    end
  endgenerate

  // Boot strap sampling at first edge after reset release
  assign sample_now      = (boot_state_reg == BOOT_SAMPLE);
  assign strap_spi       = pin_in[pin_pkg::PIN_SLAVE_SELECT];
  assign boot_state_next = BOOT_IDLE;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_state_reg <= BOOT_SAMPLE;
      boot_start_reg <= 1'b0;
      boot_spi_reg   <= 1'b0;
      boot_i2c_reg   <= 1'b0;
    end else begin
      boot_state_reg <= boot_state_next;
      boot_start_reg <= sample_now & boot_strap_select_in;
      if (sample_now && boot_strap_select_in) begin
        boot_spi_reg <= strap_spi;
        boot_i2c_reg <= ~strap_spi;
      end
    end
  end

  // Pin input capture for GPIO and master receivers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gpio_value_reg <= pin_pkg::GPIO_RESET_VALUE;
      miso_reg       <= 1'b0;
      sda_reg        <= 1'b0;
      sda2_reg       <= 1'b0;
    end else begin
      gpio_value_reg <= pin_in;
      if (first_is_spi) begin
        miso_reg <= pin_in[pin_pkg::PIN_SHARED_DATA];
      end
      sda_reg  <= pin_in[pin_pkg::PIN_SHARED_DATA];
      sda2_reg <= pin_in[pin_pkg::PIN_SECOND_DATA];
    end
  end

  assign gpio_value_out   = gpio_value_reg;
  assign spi_miso_out     = miso_reg;
  assign i2c_sda_out      = sda_reg;
  assign i2c2_sda_out     = sda2_reg;
  assign boot_start_out   = boot_start_reg;
  assign boot_use_spi_out = boot_spi_reg;
  assign boot_use_i2c_out = boot_i2c_reg;

  clock_out_divider #(
    .BASE_HALF (BASE_HALF)
  ) u_clock_out (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .mult_sel_in (clock_mult_sel_in),
    .clock_out   (master_clock_output)
  );
endmodule : master_port_pins_boot_strap

/* File: sim/pin_mux_sva.sv */
// Assertions on pad drive and boot strap outputs
// Bound to the pin mux top module
`timescale 1ns/1ns
module pin_mux_sva #(
  parameter int unsigned BASE_HALF = 16
) (
  input wire logic                clk_sys_in,
  input wire logic                rst_n_in,
  input wire logic                boot_strap_select_in,
  input wire pin_pkg::port_mode_e first_port_mode_in,
  input wire logic                second_i2c_enable_in,
  input wire logic                spi_xfer_active_in,
  input wire logic                spi_sclk_in,
  input wire logic                i2c_scl_low_in,
  input wire logic                i2c2_sda_low_in,
  input wire logic [5:0]          pin_in,
  input wire logic [5:0]          pin_out,
  input wire logic [5:0]          pin_oe_out,
  input wire logic                spi_miso_out,
  input wire logic                i2c2_sda_out,
  input wire logic                boot_start_out,
  input wire logic                boot_use_spi_out,
  input wire logic                boot_use_i2c_out
);
  wire spi_mode = first_port_mode_in == pin_pkg::MODE_SPI;
  wire i2c_mode = first_port_mode_in == pin_pkg::MODE_I2C;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_ss; spi_mode && spi_xfer_active_in |-> pin_oe_out[0] && !pin_out[0]; endproperty
  a_ss: assert property (p_ss) else $error("select not low");
  property p_sclk; spi_mode |-> pin_oe_out[2] && pin_out[2] == spi_sclk_in; endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock wrong");
  property p_miso; spi_mode |=> spi_miso_out == $past(pin_in[3]); endproperty
  a_miso: assert property (p_miso) else $error("data input not captured");
  property p_pin3; spi_mode |-> !pin_oe_out[3]; endproperty
  a_pin3: assert property (p_pin3) else $error("data input driven");
  property p_scl; i2c_mode |-> pin_oe_out[2] == i2c_scl_low_in && !(pin_oe_out[2] && pin_out[2]); endproperty
  a_scl: assert property (p_scl) else $error("clock not open drain");
  property p_sda2; second_i2c_enable_in |-> pin_oe_out[5] == i2c2_sda_low_in ##1 i2c2_sda_out == $past(pin_in[5]); endproperty
  a_sda2: assert property (p_sda2) else $error("second data wrong");
  property p_boot; rst_n_in && !$past(rst_n_in) && boot_strap_select_in |=> boot_start_out && boot_use_spi_out == $past(pin_in[0]) && boot_use_i2c_out != $past(pin_in[0]); endproperty
  a_boot: assert property (p_boot) else $error("boot choice wrong");
  property p_noboot; rst_n_in && !$past(rst_n_in) && !boot_strap_select_in |=> !boot_start_out && !boot_use_spi_out && !boot_use_i2c_out; endproperty
  a_noboot: assert property (p_noboot) else $error("boot without strap");
  property p_pulse; boot_start_out |=> !boot_start_out && $stable({boot_use_spi_out, boot_use_i2c_out}); endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse wrong");
endmodule : pin_mux_sva

bind master_port_pins_boot_strap pin_mux_sva #(.BASE_HALF(BASE_HALF)) pin_mux_sva_inst (.*);

/* File: sim/pad_partner.sv */
// Pads and far-side slaves: pull-ups, pull-downs, slave pulls
// Bench drives the slave pulls
`timescale 1ns/1ns
module pad_partner (
  input  wire logic [5:0] drive_in,
  input  wire logic [5:0] enable_in,
  input  wire logic [5:0] slave_low_in,
  input  wire logic [5:0] pull_down_in,
  output logic      [5:0] level_out
);
  wire [5:0] drv_low  = enable_in & ~drive_in;
  wire [5:0] drv_high = enable_in & drive_in;
  // Wired low, pull-up when undriven unless pull_down_in set for that pin
  assign level_out = ~(drv_low | slave_low_in) & (drv_high | ~pull_down_in);
endmodule : pad_partner

/* File: sim/master_port_pins_boot_strap_test.sv */
// Self-checking bench for the master port pin mux
// Inputs change 1 ns after each rising edge
`timescale 1ns/1ns
module master_port_pins_boot_strap_test;
  logic clk_sys_in, rst_n_in, boot_strap_select_in, second_i2c_enable_in, spi_xfer_active_in;
  logic spi_sclk_in, spi_mosi_in, i2c_scl_low_in, i2c_sda_low_in, i2c2_scl_low_in;
  logic i2c2_sda_low_in, spi_miso_out, i2c_sda_out, i2c2_sda_out, boot_start_out;
  logic boot_use_spi_out, boot_use_i2c_out, master_clock_output;
  logic [5:0] gpio_drive_in, gpio_dir_in, pin_in, pin_out, pin_oe_out, gpio_value_out;
  logic [5:0] slave_low, pull_down;
  pin_pkg::port_mode_e first_port_mode_in;
  pin_pkg::clk_mult_e  clock_mult_sel_in;
  int error_cnt, cmp_count;
  master_port_pins_boot_strap #(.BASE_HALF(8)) master_port_pins_boot_strap_inst (.*);
  pad_partner pad_partner_inst (.drive_in(pin_out), .enable_in(pin_oe_out),
    .slave_low_in(slave_low), .pull_down_in(pull_down), .level_out(pin_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic boot_test(input logic strap, input logic pd);
    rst_n_in = 1'b0;
    boot_strap_select_in = strap;
    {gpio_dir_in, slave_low, pull_down} = {12'h000, 5'h00, pd};
    tick(6);
    chk({boot_start_out, boot_use_spi_out, boot_use_i2c_out, gpio_value_out}, 16'h0000);
    rst_n_in = 1'b1;
    tick();
    chk({boot_start_out, boot_use_spi_out, boot_use_i2c_out}, {strap, strap & ~pd, strap & pd});
    tick();
    chk({boot_start_out, boot_use_spi_out, boot_use_i2c_out}, {1'b0, strap & ~pd, strap & pd});
  endtask : boot_test
  task automatic toggle(output int n);
    logic v;
    v = master_clock_output;
    n = 0;
    do begin
      tick();
      n++;
    end while (master_clock_output === v && n < 64);
  endtask : toggle
  task automatic clk_test;
    int n;
    for (int s = 0; s < 4; s++) begin
      clock_mult_sel_in = pin_pkg::clk_mult_e'(s);
      tick(40);
      toggle(n);
      toggle(n);
      chk(16'(n), 16'(8 >> s));
    end
  endtask : clk_test
  task automatic spi_test;
    first_port_mode_in = pin_pkg::MODE_SPI;
    {spi_xfer_active_in, spi_sclk_in, spi_mosi_in, slave_low} = 9'h188;
    tick();
    chk({spi_miso_out, pin_in[3:0]}, 16'h0004);
    {spi_xfer_active_in, spi_sclk_in, spi_mosi_in, slave_low} = 9'h040;
    tick();
    chk({spi_miso_out, pin_in[3:0]}, 16'h001B);
  endtask : spi_test
  task automatic i2c_test;
    first_port_mode_in = pin_pkg::MODE_I2C;
    second_i2c_enable_in = 1'b1;
    {i2c_scl_low_in, i2c_sda_low_in, i2c2_scl_low_in, i2c2_sda_low_in, slave_low} = 10'h2A0;
    tick();
    chk({i2c_sda_out, i2c2_sda_out, pin_in[5:2]}, 16'h0022);
    {i2c_scl_low_in, i2c_sda_low_in, i2c2_scl_low_in, i2c2_sda_low_in, slave_low} = 10'h140;
    tick();
    chk({i2c_sda_out, i2c2_sda_out, pin_in[5:2]}, 16'h0005);
  endtask : i2c_test
  task automatic gpio_test;
    first_port_mode_in = pin_pkg::MODE_GPIO;
    {second_i2c_enable_in, gpio_dir_in, gpio_drive_in, slave_low} = 19'h0FE90;
    tick();
    chk({gpio_value_out, pin_in}, {6'h2A, 6'h2A});
    {gpio_dir_in, slave_low} = 12'h005;
    tick();
    chk({gpio_value_out, pin_in}, {6'h3A, 6'h3A});
  endtask : gpio_test
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {rst_n_in, second_i2c_enable_in, spi_xfer_active_in, spi_sclk_in, spi_mosi_in} = 5'h00;
    {i2c_scl_low_in, i2c_sda_low_in, i2c2_scl_low_in, i2c2_sda_low_in, gpio_drive_in} = 10'h000;
    first_port_mode_in = pin_pkg::MODE_GPIO;
    clock_mult_sel_in = pin_pkg::CLK_MULT_1X;
    boot_test(1'b1, 1'b0);
    spi_test();
    i2c_test();
    gpio_test();
    clk_test();
    boot_test(1'b1, 1'b1);
    boot_test(1'b0, 1'b0);
    end_of_test();
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule : master_port_pins_boot_strap_test
